//--- common/lsc_defines.svh
// Constants of the light sensor command and readout block.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

`define LSC_SLAVE_ADDR      7'h44
`define LSC_CMD_POWER_DOWN  8'h8C
`define LSC_CMD_RESET       8'h0C
`define LSC_CMD_INT_MAIN    8'h00
`define LSC_CMD_INT_COMP    8'h04
`define LSC_CMD_INT_DIFF    8'h08
`define LSC_CMD_EXT_MAIN    8'h30
`define LSC_CMD_EXT_COMP    8'h34
`define LSC_CMD_EXT_DIFF    8'h38
`define LSC_LOOP_BIT        7
`define LSC_CMD_RESET_VAL   8'h8C
`define LSC_PHASE_LAST      15'h7FFF
`define LSC_BITS_PER_BYTE   4'h8
`define LSC_BYTES_INTERNAL  2'h1
`define LSC_BYTES_EXTERNAL  2'h3
`define LSC_IDLE_BYTE       8'hFF

`endif

//--- common/lsc_pkg.sv
// Types shared by the light sensor command and readout block.
`default_nettype none
package lsc_pkg;
	typedef enum logic [3:0] {
		LSC_IDLE, LSC_DOWN, LSC_LOOP, LSC_INT_MAIN, LSC_INT_COMP, LSC_INT_DIFF,
		LSC_EXT_MAIN, LSC_EXT_COMP, LSC_EXT_DIFF
	} lsc_mode_t;
	typedef enum logic [2:0] {
		LSC_BUS_IDLE, LSC_BUS_ADDR, LSC_BUS_ADDR_ACK, LSC_BUS_WR_DATA,
		LSC_BUS_WR_ACK, LSC_BUS_RD_DATA, LSC_BUS_RD_ACK, LSC_BUS_IGNORE
	} lsc_bus_t;
endpackage
`default_nettype wire

//--- rtl/lsc_light_sensor.sv
// Serial bus slave, command decode and integrating converter control of the light sensor.
// Function
// - Answer only slave address 1000100.
// - One 8-bit command register, overwritten by writes.
// - Address-only write repeats the stored command.
// - Reads return result then count, low first.
// - Early reads return the last completed result.
// - 8CH powers down, 0CH resets converter.
// - 00H main, 04H compensation, self-timed.
// - 08H signed difference, twice the time.
// - 30H/34H external; repeat ends and restarts.
// - 38H external difference, each receipt restarts.
// - 08H difference: compensation first, then main; 38H takes both on each tick.
// - Top bit set, other than 8CH: command byte reads back.
// - Start at once, update results when complete.
// - Four readable bytes: result and count.
// - Internal modes refuse bytes after two.
// - Internal integration lasts 32768 oscillator cycles.
// - Oscillator cycles count; count latched at end.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.svh"

module lsc_light_sensor #(
	parameter int SAMPLE_W = 8
) (
	input  wire logic                sclIn,
	input  wire logic                sdaIn,
	output logic                     sdaOut,
	output logic                     sdaOe,
	input  wire logic                oscClock,
	input  wire logic [SAMPLE_W-1:0] mainPhotoCurrent,
	input  wire logic [SAMPLE_W-1:0] compensationPhotoCurrent,
	output logic                     converterPowerDown,
	input  wire logic                clock,
	input  wire logic                resetn
);

	function automatic lsc_pkg::lsc_mode_t decodeMode(input logic [7:0] cmd);
		lsc_pkg::lsc_mode_t m;
		m = lsc_pkg::LSC_IDLE;
		if (cmd == `LSC_CMD_POWER_DOWN) begin
			m = lsc_pkg::LSC_DOWN;
		end else if (cmd[`LSC_LOOP_BIT]) begin
			m = lsc_pkg::LSC_LOOP;
		end else if (cmd == `LSC_CMD_INT_MAIN) begin
			m = lsc_pkg::LSC_INT_MAIN;
		end else if (cmd == `LSC_CMD_INT_COMP) begin
			m = lsc_pkg::LSC_INT_COMP;
		end else if (cmd == `LSC_CMD_INT_DIFF) begin
			m = lsc_pkg::LSC_INT_DIFF;
		end else if (cmd == `LSC_CMD_EXT_MAIN) begin
			m = lsc_pkg::LSC_EXT_MAIN;
		end else if (cmd == `LSC_CMD_EXT_COMP) begin
			m = lsc_pkg::LSC_EXT_COMP;
		end else if (cmd == `LSC_CMD_EXT_DIFF) begin
			m = lsc_pkg::LSC_EXT_DIFF;
		end
		return m;
	endfunction

	function automatic logic isExternal(input lsc_pkg::lsc_mode_t m);
		return (m == lsc_pkg::LSC_EXT_MAIN) || (m == lsc_pkg::LSC_EXT_COMP) ||
			(m == lsc_pkg::LSC_EXT_DIFF);
	endfunction

	// Pin synchronisers; only the second stage and later are looked at.
	logic sclS1_r, sclS2_r, sclPrev_r;
	logic sdaS1_r, sdaS2_r, sdaPrev_r;
	logic oscS1_r, oscS2_r, oscPrev_r;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			{sclS1_r, sclS2_r, sclPrev_r} <= 3'h7;
			{sdaS1_r, sdaS2_r, sdaPrev_r} <= 3'h7;
			{oscS1_r, oscS2_r, oscPrev_r} <= 3'h0;
		end else begin
			{sclS1_r, sclS2_r, sclPrev_r} <= {sclIn, sclS1_r, sclS2_r};
			{sdaS1_r, sdaS2_r, sdaPrev_r} <= {sdaIn, sdaS1_r, sdaS2_r};
			{oscS1_r, oscS2_r, oscPrev_r} <= {oscClock, oscS1_r, oscS2_r};
		end
	end

	wire logic sclRise   = sclS2_r & ~sclPrev_r;
	wire logic sclFall   = ~sclS2_r & sclPrev_r;
	wire logic busStart  = sclS2_r & sclPrev_r & sdaPrev_r & ~sdaS2_r;
	wire logic busStop   = sclS2_r & sclPrev_r & ~sdaPrev_r & sdaS2_r;
	wire logic oscTick   = oscS2_r & ~oscPrev_r;

	// Bus side state.
	lsc_pkg::lsc_bus_t busState_r, busState_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] rxShift_r, rxShift_nxt;
	logic [7:0] txShift_r, txShift_nxt;
	logic [1:0] byteIdx_r, byteIdx_nxt;
	logic       readDir_r, readDir_nxt;
	logic       masterAck_r, masterAck_nxt;
	logic       addrOnly_r, addrOnly_nxt;
	logic       sdaOe_r, sdaOe_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic       exec_r, exec_nxt;

	// Conversion side state.
	lsc_pkg::lsc_mode_t mode_r, mode_nxt;
	logic        phase_r, phase_nxt;
	logic [15:0] acc_r, acc_nxt;
	logic [15:0] cycCnt_r, cycCnt_nxt;
	logic [15:0] result_r, result_nxt;
	logic [15:0] count_r, count_nxt;

	wire lsc_pkg::lsc_mode_t cmdMode = decodeMode(cmd_r);
	wire logic addrMatch  = (rxShift_r[7:1] == `LSC_SLAVE_ADDR);
	wire logic byteDone   = (bitCnt_r == `LSC_BITS_PER_BYTE);
	wire logic [1:0] lastByte = (isExternal(mode_r) || mode_r == lsc_pkg::LSC_LOOP) ?
		`LSC_BYTES_EXTERNAL : `LSC_BYTES_INTERNAL;

	// The sensor bytes are read straight from the completed-result registers, so a read
	// during a running integration sees the previous result, never a partial sum.
	function automatic logic [7:0] readByte(input logic [1:0] idx);
		logic [7:0] b;
		b = cmd_r;
		if (mode_r != lsc_pkg::LSC_LOOP) begin
			case (idx)
				2'h0: b = result_r[7:0];
				2'h1: b = result_r[15:8];
				2'h2: b = count_r[7:0];
				default: b = count_r[15:8];
			endcase
		end
		return b;
	endfunction

	always_comb begin
		busState_nxt  = busState_r;
		bitCnt_nxt    = bitCnt_r;
		rxShift_nxt   = rxShift_r;
		txShift_nxt   = txShift_r;
		byteIdx_nxt   = byteIdx_r;
		readDir_nxt   = readDir_r;
		masterAck_nxt = masterAck_r;
		addrOnly_nxt  = addrOnly_r;
		sdaOe_nxt     = sdaOe_r;
		cmd_nxt       = cmd_r;
		exec_nxt      = 1'b0;
		if (busStop) begin
			busState_nxt = lsc_pkg::LSC_BUS_IDLE;
			sdaOe_nxt    = 1'b0;
			addrOnly_nxt = 1'b0;
			exec_nxt     = addrOnly_r;
		end else if (busStart) begin
			busState_nxt = lsc_pkg::LSC_BUS_ADDR;
			bitCnt_nxt   = 4'h0;
			sdaOe_nxt    = 1'b0;
			addrOnly_nxt = 1'b0;
		end else begin
			case (busState_r)
				lsc_pkg::LSC_BUS_ADDR, lsc_pkg::LSC_BUS_WR_DATA: begin
					if (sclRise && !byteDone) begin
						rxShift_nxt = {rxShift_r[6:0], sdaS2_r};
						bitCnt_nxt  = bitCnt_r + 4'h1;
					end else if (sclFall && byteDone) begin
						bitCnt_nxt = 4'h0;
						if (busState_r == lsc_pkg::LSC_BUS_WR_DATA) begin
							cmd_nxt      = rxShift_r;
							exec_nxt     = 1'b1;
							addrOnly_nxt = 1'b0;
							sdaOe_nxt    = 1'b1;
							busState_nxt = lsc_pkg::LSC_BUS_WR_ACK;
						end else if (addrMatch) begin
							readDir_nxt  = rxShift_r[0];
							addrOnly_nxt = ~rxShift_r[0];
							sdaOe_nxt    = 1'b1;
							busState_nxt = lsc_pkg::LSC_BUS_ADDR_ACK;
						end else begin
							busState_nxt = lsc_pkg::LSC_BUS_IGNORE;
						end
					end
				end
				lsc_pkg::LSC_BUS_ADDR_ACK: begin
					if (sclFall) begin
						if (readDir_r) begin
							byteIdx_nxt  = 2'h0;
							txShift_nxt  = readByte(2'h0);
							sdaOe_nxt    = ~txShift_nxt[7];
							busState_nxt = lsc_pkg::LSC_BUS_RD_DATA;
						end else begin
							sdaOe_nxt    = 1'b0;
							busState_nxt = lsc_pkg::LSC_BUS_WR_DATA;
						end
					end
				end
				lsc_pkg::LSC_BUS_WR_ACK: begin
					if (sclFall) begin
						sdaOe_nxt    = 1'b0;
						busState_nxt = lsc_pkg::LSC_BUS_WR_DATA;
					end
				end
				lsc_pkg::LSC_BUS_RD_DATA: begin
					if (sclFall) begin
						if (bitCnt_r == `LSC_BITS_PER_BYTE - 4'h1) begin
							bitCnt_nxt   = 4'h0;
							sdaOe_nxt    = 1'b0;
							busState_nxt = lsc_pkg::LSC_BUS_RD_ACK;
						end else begin
							bitCnt_nxt  = bitCnt_r + 4'h1;
							txShift_nxt = {txShift_r[6:0], 1'b1};
							sdaOe_nxt   = ~txShift_r[6];
						end
					end
				end
				lsc_pkg::LSC_BUS_RD_ACK: begin
					if (sclRise) begin
						masterAck_nxt = ~sdaS2_r;
					end else if (sclFall) begin
						// Past the last byte of the mode the pin stays released, which
						// the master sees as a refusal.
						if (masterAck_r && byteIdx_r != lastByte) begin
							byteIdx_nxt  = byteIdx_r + 2'h1;
							txShift_nxt  = readByte(byteIdx_r + 2'h1);
							sdaOe_nxt    = ~txShift_nxt[7];
							busState_nxt = lsc_pkg::LSC_BUS_RD_DATA;
						end else begin
							txShift_nxt  = `LSC_IDLE_BYTE;
							busState_nxt = lsc_pkg::LSC_BUS_IGNORE;
						end
					end
				end
				default: begin
					sdaOe_nxt = 1'b0;
				end
			endcase
		end
	end

	// Converter control; runs on the synchronised oscillator edges.
	wire logic phaseEnd  = oscTick && (cycCnt_r[14:0] == `LSC_PHASE_LAST);
	wire logic diffMode  = (mode_r == lsc_pkg::LSC_INT_DIFF);
	wire logic intRun    = (mode_r == lsc_pkg::LSC_INT_MAIN) ||
		(mode_r == lsc_pkg::LSC_INT_COMP) || diffMode;
	wire logic [15:0] mainExt = 16'(mainPhotoCurrent);
	wire logic [15:0] compExt = 16'(compensationPhotoCurrent);
	wire logic [15:0] accStep =
		(mode_r == lsc_pkg::LSC_INT_MAIN || mode_r == lsc_pkg::LSC_EXT_MAIN) ? acc_r + mainExt :
		(mode_r == lsc_pkg::LSC_INT_COMP || mode_r == lsc_pkg::LSC_EXT_COMP) ? acc_r + compExt :
		(mode_r == lsc_pkg::LSC_EXT_DIFF) ? acc_r + mainExt - compExt :
		(phase_r ? acc_r + mainExt : acc_r - compExt);

	always_comb begin
		mode_nxt   = mode_r;
		phase_nxt  = phase_r;
		acc_nxt    = acc_r;
		cycCnt_nxt = cycCnt_r;
		result_nxt = result_r;
		count_nxt  = count_r;
		if (exec_r) begin
			if (isExternal(cmdMode) && cmdMode == mode_r) begin
				result_nxt = acc_r;
				count_nxt  = cycCnt_r;
			end
			mode_nxt   = cmdMode;
			phase_nxt  = 1'b0;
			acc_nxt    = 16'h0000;
			cycCnt_nxt = 16'h0000;
		end else if (oscTick && (intRun || isExternal(mode_r))) begin
			acc_nxt    = accStep;
			cycCnt_nxt = cycCnt_r + 16'h0001;
			if (intRun && phaseEnd) begin
				if (diffMode && !phase_r) begin
					phase_nxt = 1'b1;
				end else begin
					result_nxt = accStep;
					count_nxt  = cycCnt_r + 16'h0001;
					phase_nxt  = 1'b0;
					acc_nxt    = 16'h0000;
					cycCnt_nxt = 16'h0000;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			busState_r  <= lsc_pkg::LSC_BUS_IDLE;
			bitCnt_r    <= 4'h0;
			rxShift_r   <= 8'h00;
			txShift_r   <= 8'hFF;
			byteIdx_r   <= 2'h0;
			readDir_r   <= 1'b0;
			masterAck_r <= 1'b0;
			addrOnly_r  <= 1'b0;
			sdaOe_r     <= 1'b0;
			cmd_r       <= `LSC_CMD_RESET_VAL;
			exec_r      <= 1'b0;
		end else begin
			busState_r  <= busState_nxt;
			bitCnt_r    <= bitCnt_nxt;
			rxShift_r   <= rxShift_nxt;
			txShift_r   <= txShift_nxt;
			byteIdx_r   <= byteIdx_nxt;
			readDir_r   <= readDir_nxt;
			masterAck_r <= masterAck_nxt;
			addrOnly_r  <= addrOnly_nxt;
			sdaOe_r     <= sdaOe_nxt;
			cmd_r       <= cmd_nxt;
			exec_r      <= exec_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			mode_r   <= lsc_pkg::LSC_DOWN;
			phase_r  <= 1'b0;
			acc_r    <= 16'h0000;
			cycCnt_r <= 16'h0000;
			result_r <= 16'h0000;
			count_r  <= 16'h0000;
		end else begin
			mode_r   <= mode_nxt;
			phase_r  <= phase_nxt;
			acc_r    <= acc_nxt;
			cycCnt_r <= cycCnt_nxt;
			result_r <= result_nxt;
			count_r  <= count_nxt;
		end
	end

	// Open-drain: the pin is only ever pulled low.
	assign sdaOut             = 1'b0;
	assign sdaOe              = sdaOe_r;
	assign converterPowerDown = (mode_r == lsc_pkg::LSC_DOWN);

endmodule
`default_nettype wire

//--- test/lsc_light_sensor_monitor.sv
// Port checks of the light sensor block.
`timescale 1ns/1ps
`default_nettype none
module lsc_light_sensor_monitor #(
	parameter int SAMPLE_W = 8
) (
	input wire logic                clock,
	input wire logic                resetn,
	input wire logic                sclIn,
	input wire logic                sdaIn,
	input wire logic                sdaOut,
	input wire logic                sdaOe,
	input wire logic                oscClock,
	input wire logic [SAMPLE_W-1:0] mainPhotoCurrent,
	input wire logic [SAMPLE_W-1:0] compensationPhotoCurrent,
	input wire logic                converterPowerDown
);
	logic       sclQ, sdaQ, busy, hit, rd;
	logic [3:0] nBit;
	logic [1:0] nByte;
	logic [7:0] sh;
	wire        sclRise = sclIn & ~sclQ;
	wire        startC  = sclIn & sclQ & sdaQ & ~sdaIn;
	wire        stopC   = sclIn & sclQ & ~sdaQ & sdaIn;
	wire        ackBit  = sclRise & (nBit == 4'h8);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clock) begin
		sclQ <= sclIn;
		sdaQ <= sdaIn;
		busy <= resetn & ~stopC & (busy | startC);
		if (!resetn || startC) begin
			nBit <= 4'h0;
			nByte <= 2'h0;
		end else if (sclRise) begin
			nBit <= ackBit ? 4'h0 : nBit + 4'h1;
			if (!ackBit)
				sh <= {sh[6:0], sdaIn};
			if (ackBit && nByte != 2'h3)
				nByte <= nByte + 2'h1;
			if (ackBit && nByte == 2'h0) begin
				hit <= sh[7:1] == 7'h44;
				rd <= sh[0];
			end
		end
	end
	a_reset_idle: assert property (disable iff (1'b0) !resetn |=> converterPowerDown && !sdaOe)
		else $error("state after reset wrong");
	a_own_address: assert property (ackBit && nByte == 2'h0 |-> sdaOe == (sh[7:1] == 7'h44))
		else $error("address acknowledge wrong");
	a_foreign_silent: assert property (busy && nByte != 2'h0 && !hit |-> !sdaOe)
		else $error("drives bus for another address");
	a_idle_release: assert property (!busy |-> !sdaOe)
		else $error("drives bus outside a transfer");
	a_ack_command: assert property (ackBit && nByte != 2'h0 && hit && !rd |-> sdaOe)
		else $error("command byte not acknowledged");
	a_master_ack: assert property (ackBit && nByte != 2'h0 && rd |-> !sdaOe)
		else $error("master acknowledge slot blocked");
	a_scl_low_move: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data moved while clock high");
	a_pd_decode: assert property (ackBit && nByte == 2'h1 && hit && !rd
		|-> converterPowerDown == (sh == 8'h8C))
		else $error("power down decode wrong");
	a_pd_by_bus: assert property ($changed(converterPowerDown) |-> busy)
		else $error("mode moved without a write");
	a_drive_low: assert property (sdaOe |-> !sdaOut)
		else $error("data pin driven high");
endmodule
bind lsc_light_sensor lsc_light_sensor_monitor #(.SAMPLE_W(SAMPLE_W)) u_monitor (
	.clock(clock), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .oscClock(oscClock), .mainPhotoCurrent(mainPhotoCurrent),
	.compensationPhotoCurrent(compensationPhotoCurrent), .converterPowerDown(converterPowerDown)
);
`default_nettype wire

//--- test/lsc_bus_master.sv
// Serial bus master model driving the light sensor block.
`timescale 1ns/1ps
`default_nettype none
module lsc_bus_master #(
	parameter int HALF = 16
) (
	input  wire logic clock,
	input  wire logic sdaLine,
	output var logic  sclOut,
	output var logic  sdaDrive
);
	initial begin
		sclOut = 1'b1;
		sdaDrive = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Data moves two cycles after the clock falls, so it never races the fall.
	task automatic bitx(input logic b, output logic r);
		tick(2);
		sdaDrive = b;
		tick(HALF);
		sclOut = 1'b1;
		tick(HALF);
		r = sdaLine;
		sclOut = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ackIn, ack);
	endtask
	task automatic start();
		tick(HALF);
		sdaDrive = 1'b0;
		tick(HALF);
		sclOut = 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sdaDrive = 1'b0;
		tick(HALF);
		sclOut = 1'b1;
		tick(HALF);
		sdaDrive = 1'b1;
		tick(HALF);
	endtask
endmodule
`default_nettype wire

//--- test/lsc_light_sensor_tb_top.sv
// Self-checking bench of the light sensor block.
`timescale 1ns/1ps
`default_nettype none
module lsc_light_sensor_tb_top;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic       oscClock = 1'b0;
	logic [7:0] mainPc = 8'h00;
	logic [7:0] compPc = 8'h00;
	logic [7:0] lfsr = 8'h46;
	logic [7:0] lb;
	logic [7:0] rb [4];
	logic [7:0] codes [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h8C};
	logic [7:0] ext [3] = '{8'h30, 8'h34, 8'h38};
	logic       sdaOut, sdaOe, pd, sclLine, sdaDrive;
	wire        sdaLine = sdaDrive & (sdaOe ? sdaOut : 1'b1);
	int         failures = 0;
	int         nChecks = 0;
	int         expRes = 0;
	int         expCnt = 0;
	int         n;
	always #2 clock = ~clock;
	lsc_light_sensor u_lsc_light_sensor (.sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .oscClock(oscClock), .mainPhotoCurrent(mainPc),
		.compensationPhotoCurrent(compPc), .converterPowerDown(pd), .clock(clock),
		.resetn(resetn));
	lsc_bus_master u_lsc_bus_master (.clock(clock), .sdaLine(sdaLine), .sclOut(sclLine),
		.sdaDrive(sdaDrive));
	function automatic logic [7:0] nextRand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", nChecks, failures);
		if (failures == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic withCmd);
		logic [7:0] q;
		logic       ack;
		u_lsc_bus_master.start();
		u_lsc_bus_master.xfer(a, 1'b1, q, ack);
		check(ack, a != 8'h88);
		if (withCmd)
			u_lsc_bus_master.xfer(c, 1'b1, q, ack);
		u_lsc_bus_master.stop();
	endtask
	task automatic rd(input int cnt);
		logic [7:0] q;
		logic       ack;
		u_lsc_bus_master.start();
		u_lsc_bus_master.xfer(8'h89, 1'b1, q, ack);
		for (int k = 0; k < cnt; k++)
			u_lsc_bus_master.xfer(8'hFF, k == cnt - 1, rb[k], ack);
		u_lsc_bus_master.stop();
	endtask
	// The oscillator is paced between transfers so every tick count is exact.
	task automatic pulses(input int cnt);
		repeat (cnt) begin
			repeat (4) @(posedge clock);
			#1 oscClock = 1'b1;
			repeat (4) @(posedge clock);
			#1 oscClock = 1'b0;
		end
	endtask
	task automatic res4();
		check({rb[1], rb[0]}, expRes[15:0]);
		check({rb[3], rb[2]}, expCnt[15:0]);
	endtask
	task automatic setExp(input int i, input int cnt);
		expCnt = cnt;
		expRes = cnt * (i == 0 ? int'(mainPc) : i == 1 ? int'(compPc) : int'(mainPc) - int'(compPc));
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#1 resetn = 1'b1;
		check(pd, 1'b1);
		wr(8'h8A, 8'h30, 1'b1);
		check(pd, 1'b1);
		foreach (codes[i]) begin
			wr(8'h88, codes[i], 1'b1);
			pulses(50);
			rd(3);
			check({rb[1], rb[0]}, expRes[15:0]);
			check(rb[2], 8'hFF);
			check(pd, codes[i] == 8'h8C);
		end
		lfsr = nextRand(lfsr);
		lb = lfsr | 8'hC0;
		wr(8'h88, lb, 1'b1);
		rd(4);
		foreach (rb[k])
			check(rb[k], lb);
		check(pd, 1'b0);
		foreach (ext[i]) begin
			wr(8'h88, ext[i], 1'b1);
			lfsr = nextRand(lfsr);
			mainPc = lfsr;
			n = 20 + int'(lfsr);
			lfsr = nextRand(lfsr);
			compPc = lfsr;
			pulses(n);
			rd(4);
			res4();
			wr(8'h88, ext[i], 1'b1);
			setExp(i, n);
			rd(4);
			res4();
			pulses(7);
			wr(8'h88, 8'h00, 1'b0);
			setExp(i, 7);
			rd(4);
			res4();
		end
		wr(8'h88, 8'h8C, 1'b1);
		rd(2);
		check({rb[1], rb[0]}, expRes[15:0]);
		summarize();
	end
	initial begin
		repeat (100000) @(posedge clock);
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
